// [include/efc_params.svh]
/*
 * Constants of the embedded flash controller: register offsets, field
 * positions, reset values and operation lengths in microseconds.
 * Assumes inclusion by bare name from the controller's design file.
 */
`ifndef EFC_PARAMS_SVH
`define EFC_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define EFC_OFF_ADDR      12'h000
`define EFC_OFF_DATA      12'h004
`define EFC_OFF_CTRL      12'h008
`define EFC_OFF_RDEN      12'h130
`define EFC_OFF_PGEN      12'h134
`define EFC_OFF_USEC      12'h140
`define EFC_OFF_STAT      12'h144

// =====================================================================
// Control register fields and key
`define EFC_KEY           16'ha442
`define EFC_BIT_WRITE     0
`define EFC_BIT_ERASE     1
`define EFC_BIT_MASS      2
`define EFC_BIT_COMMIT    3
`define EFC_DEBUG_ADDR    16'h0900
`define EFC_DEBUG_ON      2'h2

// =====================================================================
// Reset values
`define EFC_USEC_RST      8'h31
`define EFC_RDEN_RST      32'hbfffffff
`define EFC_PGEN_RST      32'hffffffff

// =====================================================================
// Operation lengths in microseconds
`define EFC_PROG_US       18'd50
`define EFC_ERASE_US      18'd25000
`define EFC_MASS_US       18'd200000
`define EFC_COMMIT_US     18'd100

`endif

// [include/efc_pkg.sv]
/*
 * Types shared by the embedded flash controller.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package efc_pkg;
    // =================================================================
    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        EFC_IDLE = 2'b01,
        EFC_BUSY = 2'b10
    } efc_state_t;
endpackage

`default_nettype wire

// [rtl/efc_top.sv]
/*
 * Embedded flash controller: Wishbone register slave, per-block
 * protection, microsecond-timed program, erase and commit sequencing.
 * Assumes the array holds the committed protection words on nv_*_i and
 * stores nv_data_o when a commit ends; data reads come one per cycle.
 */
// Our own choices: the Wishbone register port and the placing of the registers.
// Operation
// - Time operations from cycles-per-microsecond minus one
// - Reload resets to fastest-clock safe value
// - Two 32-bit vectors, one bit per block
// - Program-enable clear refuses any block change
// - Read-enable clear still allows instruction fetch
// - Protected program or erase is suppressed
// - Protected data read returns zero, flags
// - Factory state: all protection bits set; read-enable bit 30 resets clear (debug field 0x2)
// - Protection writes temporary until committed
// - Address bit 0 selects committed vector
// - Commit bit starts nonvolatile write
// - Address 0x900 commits debug field, cleared bits
// - Debug field 0x2 enables debug port
// - Committed debug setting acts after power-up
// - Only debug port blocked, test port stays
// - Page erase via address then control
// - Mass erase via control, bit stays set
// - Operation bit reads one while pending
`timescale 1ns/1ps
`default_nettype none
`include "efc_params.svh"

module efc_top (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [11:0]       adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    input  wire logic [31:0]       nv_rden_i,
    input  wire logic [31:0]       nv_pgen_i,
    input  wire logic              data_req_i,
    input  wire logic              data_fetch_i,
    input  wire logic [15:0]       data_addr_i,
    input  wire logic [31:0]       array_rdata_i,
    output logic      [31:0]       data_rdata_o,
    output logic                   data_valid_o,
    output logic      [3:0]        flash_op_o,
    output logic      [15:0]       flash_addr_o,
    output logic      [31:0]       flash_wdata_o,
    output logic                   nv_sel_pgen_o,
    output logic      [31:0]       nv_data_o,
    output logic                   debug_port_enable_o,
    output efc_pkg::efc_state_t    state_o
);
    import efc_pkg::*;

    // =================================================================
    // State
    logic [15:0] flash_target_address, next_addr;
    logic [31:0] flash_write_data, next_data;
    logic [3:0]  op, next_op;
    logic [31:0] read_enable_bits, next_rden;
    logic [31:0] program_enable_bits, next_pgen;
    logic [7:0]  microsecond_reload, next_reload;
    logic [7:0]  us_cnt, next_us_cnt;
    logic [17:0] us_left, next_us_left;
    logic [1:0]  viol, next_viol;
    logic [31:0] next_dat, next_rdata, next_nv;
    logic        next_ack, next_valid, next_sel, next_debug_port;
    efc_state_t  state, next_state;
    logic        req, wr, start, allowed, key_ok;
    logic [31:0] wmask;
    logic [4:0]  blk;

    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign blk = flash_target_address[15:11];
    assign key_ok = (dat_i[31:16] == `EFC_KEY) && (sel_i == 4'hf);
    // Start only when idle with the key and a nonzero operation bit
    assign start = wr && (adr_i == `EFC_OFF_CTRL) && key_ok
                   && (state == EFC_IDLE) && (dat_i[3:0] != 4'h0);
    // Program and erase need the block enabled, mass erase needs all
    always_comb begin
        if (dat_i[`EFC_BIT_COMMIT])
            allowed = 1'b1;
        else if (dat_i[`EFC_BIT_MASS])
            allowed = &program_enable_bits;
        else
            allowed = program_enable_bits[blk];
    end

    // =================================================================
    // Next values of registers, sequencer and read path
    always_comb begin
        next_addr = flash_target_address;
        next_data = flash_write_data;
        next_op = op;
        next_rden = read_enable_bits;
        next_pgen = program_enable_bits;
        next_reload = microsecond_reload;
        next_us_cnt = us_cnt;
        next_us_left = us_left;
        next_viol = viol;
        next_state = state;
        next_sel = nv_sel_pgen_o;
        next_nv = nv_data_o;
        next_debug_port = debug_port_enable_o;
        next_ack = req;
        next_dat = 32'h0;
        next_valid = data_req_i;
        next_rdata = 32'h0;

        // Register writes; protection bits committed at zero stay zero
        if (wr) begin
            case (adr_i)
                `EFC_OFF_ADDR: next_addr = (flash_target_address & ~wmask[15:0])
                                          | (dat_i[15:0] & wmask[15:0]);
                `EFC_OFF_DATA: next_data = (flash_write_data & ~wmask) | (dat_i & wmask);
                `EFC_OFF_RDEN: next_rden = ((read_enable_bits & ~wmask)
                                           | (dat_i & wmask)) & nv_rden_i;
                `EFC_OFF_PGEN: next_pgen = ((program_enable_bits & ~wmask)
                                           | (dat_i & wmask)) & nv_pgen_i;
                `EFC_OFF_USEC: if (sel_i[0]) next_reload = dat_i[7:0];
                `EFC_OFF_STAT: next_viol = viol & ~dat_i[1:0];
                default: ;
            endcase
        end

        // Register reads; unmapped offsets read zero and still ack
        if (req && !we_i) begin
            case (adr_i)
                `EFC_OFF_ADDR: next_dat = {16'h0, flash_target_address};
                `EFC_OFF_DATA: next_dat = flash_write_data;
                `EFC_OFF_CTRL: next_dat = {28'h0, op};
                `EFC_OFF_RDEN: next_dat = read_enable_bits;
                `EFC_OFF_PGEN: next_dat = program_enable_bits;
                `EFC_OFF_USEC: next_dat = {24'h0, microsecond_reload};
                `EFC_OFF_STAT: next_dat = {30'h0, viol};
                default: next_dat = 32'h0;
            endcase
        end

        // Sequencer; a single set bit is expected, commit ranks first
        case (state)
            EFC_IDLE: begin
                if (start && !allowed) begin
                    next_viol[0] = 1'b1;
                end else if (start) begin
                    next_state = EFC_BUSY;
                    next_us_cnt = microsecond_reload;
                    if (dat_i[`EFC_BIT_COMMIT]) begin
                        next_op = 4'h8;
                        next_us_left = `EFC_COMMIT_US;
                        next_sel = flash_target_address[0];
                        if (flash_target_address == `EFC_DEBUG_ADDR) begin
                            next_sel = 1'b0;
                            next_nv = {read_enable_bits[31:30],
                                       nv_rden_i[29:0] & read_enable_bits[29:0]};
                        end else if (flash_target_address[0])
                            next_nv = program_enable_bits;
                        else
                            next_nv = {nv_rden_i[31:30], read_enable_bits[29:0]};
                    end else if (dat_i[`EFC_BIT_MASS]) begin
                        next_op = 4'h4;
                        next_us_left = `EFC_MASS_US;
                    end else if (dat_i[`EFC_BIT_ERASE]) begin
                        next_op = 4'h2;
                        next_us_left = `EFC_ERASE_US;
                    end else begin
                        next_op = 4'h1;
                        next_us_left = `EFC_PROG_US;
                    end
                end
            end
            EFC_BUSY: begin
                // Reload plus one cycles make one microsecond
                if (us_cnt == 8'h0) begin
                    next_us_cnt = microsecond_reload;
                    next_us_left = us_left - 18'd1;
                    if (us_left == 18'd1) begin
                        next_state = EFC_IDLE;
                        next_op = 4'h0;
                    end
                end else
                    next_us_cnt = us_cnt - 8'd1;
            end
            default: next_state = EFC_IDLE;
        endcase

        // Data reads of a read-protected block give zero; fetch passes
        if (data_req_i && !data_fetch_i && !read_enable_bits[data_addr_i[15:11]]) begin
            next_rdata = 32'h0;
            next_viol[1] = 1'b1;
        end else if (data_req_i)
            next_rdata = array_rdata_i;

        // Status bits: a new event beats a same-cycle clear
        if (start && !allowed)
            next_viol[0] = 1'b1;

        // Reset: working bits restored from committed ones
        if (rst_i) begin
            next_addr = 16'h0;
            next_data = 32'h0;
            next_op = 4'h0;
            next_rden = nv_rden_i;
            next_pgen = nv_pgen_i;
            next_reload = `EFC_USEC_RST;
            next_us_cnt = 8'h0;
            next_us_left = 18'h0;
            next_viol = 2'h0;
            next_state = EFC_IDLE;
            next_sel = 1'b0;
            next_nv = 32'h0;
            next_ack = 1'b0;
            next_dat = 32'h0;
            next_valid = 1'b0;
            next_rdata = 32'h0;
            // Debug port only; test access port is not gated here
            next_debug_port = (nv_rden_i[31:30] == `EFC_DEBUG_ON);
        end
    end

    // =================================================================
    // Registers
    always_ff @(posedge clk_i) begin
        flash_target_address <= next_addr;
        flash_write_data <= next_data;
        op <= next_op;
        read_enable_bits <= next_rden;
        program_enable_bits <= next_pgen;
        microsecond_reload <= next_reload;
        us_cnt <= next_us_cnt;
        us_left <= next_us_left;
        viol <= next_viol;
        state <= next_state;
        nv_sel_pgen_o <= next_sel;
        nv_data_o <= next_nv;
        debug_port_enable_o <= next_debug_port;
        ack_o <= next_ack;
        dat_o <= next_dat;
        data_valid_o <= next_valid;
        data_rdata_o <= next_rdata;
        flash_op_o <= next_op;
        flash_addr_o <= next_addr;
        flash_wdata_o <= next_data;
        state_o <= next_state;
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_read_block_zero: assert property (data_req_i && !data_fetch_i
        && !read_enable_bits[data_addr_i[15:11]] |=> data_rdata_o == 32'h0 && viol[1])
        else $error("protected data read not zeroed");
    a_prog_suppress: assert property (start && !allowed |=> state == EFC_IDLE
        && op == 4'h0) else $error("protected operation started");
    a_bad_key_ignored: assert property (wr && adr_i == `EFC_OFF_CTRL
        && !key_ok && state == EFC_IDLE |=> state == EFC_IDLE)
        else $error("keyless control write started work");
    a_commit_readback: assert property (state == EFC_BUSY && op[`EFC_BIT_COMMIT]
        && req && !we_i && adr_i == `EFC_OFF_CTRL |=> dat_o[`EFC_BIT_COMMIT])
        else $error("commit bit read back low while pending");
    a_tick_reload: assert property (state == EFC_BUSY && us_cnt == 8'h0
        && us_left != 18'd1 |=> us_cnt == $past(microsecond_reload))
        else $error("microsecond counter not reloaded");
    a_reset_reload: assert property ($fell(rst_i)
        |-> microsecond_reload == `EFC_USEC_RST)
        else $error("reload value wrong after reset");
    a_debug_port_stable: assert property (!$past(rst_i)
        |-> $stable(debug_port_enable_o))
        else $error("debug port enable changed without reset");
    a_debug_commit: assert property (start && dat_i[`EFC_BIT_COMMIT]
        && flash_target_address == `EFC_DEBUG_ADDR
        |=> nv_data_o[31:30] == $past(read_enable_bits[31:30]) && !nv_sel_pgen_o)
        else $error("debug field commit data wrong");
    a_done_clears: assert property (state == EFC_BUSY ##1 state == EFC_IDLE
        |-> op == 4'h0 && flash_op_o == 4'h0)
        else $error("operation bit left set after completion");

    // Protection, fetch and start paths against their rules
    a_sticky_zero: assert property (wr && adr_i == `EFC_OFF_RDEN
        |=> (read_enable_bits & ~$past(nv_rden_i)) == 32'h0)
        else $error("committed read zero set back to one");
    a_reset_vectors: assert property ($fell(rst_i)
        |-> read_enable_bits == $past(nv_rden_i) && program_enable_bits == $past(nv_pgen_i))
        else $error("protection vectors not restored at reset");
    a_start_allowed: assert property (start && allowed
        |=> state == EFC_BUSY && flash_op_o != 4'h0)
        else $error("permitted operation did not start");
    a_fetch_passes: assert property (data_req_i && data_fetch_i
        |=> data_valid_o && data_rdata_o == $past(array_rdata_i))
        else $error("instruction fetch data not passed");

endmodule // efc_top

`default_nettype wire

// [tb/efc_flash_model.sv]
/*
 * Behavioural flash array: committed protection words and read data.
 * Assumes the controller holds flash_op_i[3] high for a whole commit.
 */
`timescale 1ns/1ps
`default_nettype none

module efc_flash_model (
    input  wire logic        clk_i,
    input  wire logic [3:0]  flash_op_i,
    input  wire logic        nv_sel_pgen_i,
    input  wire logic [31:0] nv_data_i,
    input  wire logic [15:0] data_addr_i,
    output logic      [31:0] nv_rden_o,
    output logic      [31:0] nv_pgen_o,
    output logic      [31:0] array_rdata_o
);
    // =================================================================
    // Committed words, factory state: open access except data reads of block 30, debug port enabled
    logic commit_q;
    initial begin
        nv_rden_o = 32'hbfffffff;
        nv_pgen_o = 32'hffffffff;
        commit_q  = 1'b0;
    end

    // Store when a commit ends; no reset, so words survive power-on
    always @(posedge clk_i) begin
        commit_q <= flash_op_i[3];
        if (commit_q && !flash_op_i[3]) begin
            if (nv_sel_pgen_i) begin
                nv_pgen_o <= nv_data_i;
            end else begin
                nv_rden_o <= nv_data_i;
            end
        end
    end

    // Address pattern, so a zeroed read can never pass by accident
    assign array_rdata_o = {~data_addr_i, data_addr_i};
endmodule // efc_flash_model
`default_nettype wire

// [tb/test_embedded_flash_controller.sv]
/*
 * Self-checking bench for the flash controller: Wishbone tasks, one
 * task per scenario. Assumes efc_top and efc_flash_model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

module test_embedded_flash_controller;
    import efc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0]  sel_i = 4'hf, flash_op_o;
    logic [31:0] dat_i = 32'h0, dat_o, nv_rden_i, nv_pgen_i, array_rdata_i;
    logic [31:0] data_rdata_o, flash_wdata_o, nv_data_o, rd;
    logic        data_req_i = 1'b0, data_fetch_i = 1'b0, ack_o, data_valid_o;
    logic        nv_sel_pgen_o, debug_port_enable_o, op_prev = 1'b0;
    logic [15:0] data_addr_i = 16'h0, flash_addr_o;
    efc_state_t  state_o;
    int          miscompares = 0, checks = 0, op_len = 0;

    always #20 clk_i = ~clk_i;

    efc_top u_efc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .nv_rden_i(nv_rden_i), .nv_pgen_i(nv_pgen_i),
        .data_req_i(data_req_i), .data_fetch_i(data_fetch_i),
        .data_addr_i(data_addr_i), .array_rdata_i(array_rdata_i),
        .data_rdata_o(data_rdata_o), .data_valid_o(data_valid_o),
        .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o),
        .flash_wdata_o(flash_wdata_o), .nv_sel_pgen_o(nv_sel_pgen_o),
        .nv_data_o(nv_data_o), .debug_port_enable_o(debug_port_enable_o),
        .state_o(state_o));

    efc_flash_model u_efc_flash_model (.clk_i(clk_i), .flash_op_i(flash_op_o),
        .nv_sel_pgen_i(nv_sel_pgen_o), .nv_data_i(nv_data_o),
        .data_addr_i(data_addr_i), .nv_rden_o(nv_rden_i), .nv_pgen_o(nv_pgen_i),
        .array_rdata_o(array_rdata_i));

    // =================================================================
    // Length of the latest operation in cycles, restarted per operation
    always @(posedge clk_i) begin
        op_prev <= (flash_op_o !== 4'h0);
        if (flash_op_o !== 4'h0) begin
            op_len <= op_prev ? op_len + 1 : 1;
        end
    end

    // =================================================================
    // Bus and helper tasks
    task automatic wb_cycle(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        // Hold everything until ack is sampled; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Start an operation, poll until its bit drops, check its length
    task automatic run_op(input logic [31:0] cmd, input int len);
        int n;
        n = 0;
        wb_cycle(1'b1, 12'h008, cmd);
        wb_cycle(1'b0, 12'h008, 32'h0);
        `CHK(rd[3:0], cmd[3:0])
        `CHK(state_o, EFC_BUSY)
        // Bounded poll; a hang reaches the watchdog before this bound runs out
        do begin
            wb_cycle(1'b0, 12'h008, 32'h0);
            n++;
        end while (rd[3:0] !== 4'h0 && n < 30000);
        `CHK(rd[3:0], 4'h0)
        `CHK(state_o, EFC_IDLE)
        `CHK(op_len, len)
    endtask

    task automatic data_read(input logic f, input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        data_req_i <= 1'b1;
        data_fetch_i <= f;
        data_addr_i <= a;
        @(posedge clk_i);
        data_req_i <= 1'b0;
        @(posedge clk_i);
        `CHK(data_valid_o, 1'b1)
        `CHK(data_rdata_o, exp)
    endtask

    // =================================================================
    // Scenarios
    task automatic t_reset_values;
        wb_cycle(1'b0, 12'h140, 32'h0);
        `CHK(rd, 32'h00000031)
        wb_cycle(1'b0, 12'h130, 32'h0);
        `CHK(rd, 32'hbfffffff)
        wb_cycle(1'b0, 12'h134, 32'h0);
        `CHK(rd, 32'hffffffff)
        `CHK(debug_port_enable_o, 1'b1)
    endtask

    task automatic t_program;
        wb_cycle(1'b1, 12'h140, 32'h1);
        wb_cycle(1'b1, 12'h004, 32'h12345678);
        wb_cycle(1'b1, 12'h000, 32'h0104);
        run_op(32'ha4420001, 100);
        `CHK(flash_wdata_o, 32'h12345678)
        `CHK(flash_addr_o, 16'h0104)
        // Wrong key must not start anything
        wb_cycle(1'b1, 12'h008, 32'h5a5a0001);
        wb_cycle(1'b0, 12'h008, 32'h0);
        `CHK(rd[3:0], 4'h0)
        `CHK(flash_op_o, 4'h0)
    endtask

    task automatic t_protect_prog;
        wb_cycle(1'b1, 12'h134, 32'hfffffffe);
        wb_cycle(1'b0, 12'h134, 32'h0);
        `CHK(rd, 32'hfffffffe)
        wb_cycle(1'b1, 12'h144, 32'h3);
        wb_cycle(1'b1, 12'h000, 32'h0010);
        wb_cycle(1'b1, 12'h008, 32'ha4420001);
        `CHK(flash_op_o, 4'h0)
        wb_cycle(1'b1, 12'h008, 32'ha4420004);
        wb_cycle(1'b0, 12'h008, 32'h0);
        `CHK(rd[3:0], 4'h0)
        wb_cycle(1'b0, 12'h144, 32'h0);
        `CHK(rd[0], 1'b1)
        wb_cycle(1'b1, 12'h140, 32'h0);
        wb_cycle(1'b1, 12'h000, 32'h0800);
        run_op(32'ha4420002, 25000);
    endtask

    task automatic t_read_protect;
        wb_cycle(1'b1, 12'h130, 32'hbffffffd);
        wb_cycle(1'b1, 12'h144, 32'h3);
        data_read(1'b0, 16'h0804, 32'h0);
        data_read(1'b1, 16'h0804, {~16'h0804, 16'h0804});
        data_read(1'b0, 16'h0004, {~16'h0004, 16'h0004});
        wb_cycle(1'b0, 12'h144, 32'h0);
        `CHK(rd[1], 1'b1)
    endtask

    // Commit the read vector, then the program vector after a reset
    task automatic t_commit;
        wb_cycle(1'b1, 12'h140, 32'h0);
        wb_cycle(1'b1, 12'h000, 32'h0);
        run_op(32'ha4420008, 100);
        `CHK(nv_sel_pgen_o, 1'b0)
        do_reset;
        wb_cycle(1'b0, 12'h130, 32'h0);
        `CHK(rd, 32'hbffffffd)
        wb_cycle(1'b0, 12'h134, 32'h0);
        `CHK(rd, 32'hffffffff)
        wb_cycle(1'b1, 12'h140, 32'h0);
        wb_cycle(1'b1, 12'h134, 32'hfffffffe);
        wb_cycle(1'b1, 12'h000, 32'h0001);
        run_op(32'ha4420008, 100);
        `CHK(nv_sel_pgen_o, 1'b1)
        do_reset;
        wb_cycle(1'b0, 12'h134, 32'h0);
        `CHK(rd, 32'hfffffffe)
    endtask

    task automatic t_debug;
        wb_cycle(1'b1, 12'h140, 32'h0);
        wb_cycle(1'b1, 12'h130, 32'h3ffffffd);
        wb_cycle(1'b1, 12'h000, 32'h0900);
        run_op(32'ha4420008, 100);
        `CHK(debug_port_enable_o, 1'b1)
        do_reset;
        `CHK(debug_port_enable_o, 1'b0)
        wb_cycle(1'b0, 12'h130, 32'h0);
        `CHK(rd, 32'h3ffffffd)
    endtask

    // =================================================================
    // Verdict and run control
    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Longest path is the page erase; this leaves ample margin
    initial begin
        repeat (90000) @(posedge clk_i);
        miscompares++;
        summarize;
    end

    initial begin
        do_reset;
        t_reset_values;
        t_program;
        t_protect_prog;
        t_read_protect;
        t_commit;
        t_debug;
        summarize;
    end
endmodule // test_embedded_flash_controller
`default_nettype wire
